// ===== src/pcecs_ident.sv
`timescale 1ns/1ps

// ***************************************************************
// maker identifier holder with load paths
// ***************************************************************
module pcecs_ident
  import pcecs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        smbus_id_we,
  input  wire logic [15:0] smbus_id_data,
  input  wire logic        eeprom_id_we,
  input  wire logic [15:0] eeprom_id_data,
  output logic      [15:0] maker_identifier
);

  // default at reset, replaced by smbus (wins) or eeprom load
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      maker_identifier <= MAKER_ID_RESET;
    end else if (smbus_id_we) begin
      maker_identifier <= smbus_id_data;
    end else if (eeprom_id_we) begin
      maker_identifier <= eeprom_id_data;
    end
  end

endmodule // pcecs_ident

// ===== src/pcecs_map.sv
`timescale 1ns/1ps

// Summary of operation
// - The first extended capability sits at 100h with capability id 0001h for error reporting.
// - All further extended capabilities sit above 0FFh in configuration space.
// - Error reporting, virtual channel and power budgeting registers are reachable by configuration access.
// - Error registers lie at 104h through 118h and the header log at 11Ch through 128h.
// - The chain runs 140h to 20Ch, then to 220h or 230h, and both of those end with next pointer 000h.
// - The maker identifier reads at bits 15:0 of offset 00h and can be replaced by smbus or eeprom load.
module pcecs_map
  import pcecs_pkg::*;
#(
  parameter bit PB_NEXT_TO_LTR = 1'b0,
  parameter int PB_DEPTH       = PB_ENTRIES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        smbus_id_we,
  input  wire logic [15:0] smbus_id_data,
  input  wire logic        eeprom_id_we,
  input  wire logic [15:0] eeprom_id_data,
  input  wire logic [31:0] unc_event,
  input  wire logic [31:0] cor_event,
  input  wire logic        hlog_we,
  input  wire logic [127:0] hlog_data,
  input  wire logic        pb_we,
  input  wire logic [$clog2(PB_DEPTH)-1:0] pb_widx,
  input  wire logic [31:0] pb_wdata,
  output logic      [31:0] unc_mask_out,
  output logic      [31:0] unc_sev_out,
  output logic      [31:0] cor_mask_out
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [31:0] cap_hdr(input logic [15:0] id, input logic [11:0] nxt);
    cap_hdr = {nxt, CAP_VERSION, id};
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [31:0] wm);
    logic [31:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~(lane & wm)) | (wd & lane & wm);
  endfunction

  // write-one-to-clear; a new event in the same cycle stays set
  function automatic logic [31:0] w1c(input logic [31:0] old, input logic [31:0] wd,
                                      input logic [3:0] be, input logic [31:0] ev);
    logic [31:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    w1c = (old & ~(wd & lane)) | ev;
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  logic [15:0]  maker_identifier;
  logic [31:0]  uncorrectable_fault_flags;
  logic [31:0]  uncorrectable_fault_mask;
  logic [31:0]  uncorrectable_fault_severity;
  logic [31:0]  correctable_fault_flags;
  logic [31:0]  correctable_fault_mask;
  logic [31:0]  error_report_cap_control;
  logic [127:0] faulting_header_record;
  logic [31:0]  port_channel_ctrl_status;
  logic [31:0]  channel0_resource_control;
  logic [31:0]  channel1_resource_control;
  logic [31:0]  power_budget_selector;
  logic [31:0]  access_services_cap_ctrl;
  logic [31:0]  egress_permission_vector;
  logic [31:0]  max_latency_limits;
  logic [31:0]  power_budget_value;
  logic [31:0]  next_rdata;
  logic [11:0]  pb_next;
  logic         hit_rd;
  logic         pending_q;
  logic [31:0]  direct_q;
  logic         use_pb_q;

  assign pb_next = PB_NEXT_TO_LTR ? OFS_LTR_HDR : OFS_ACS_HDR;

  // ***************************************************************
  // submodules
  // ***************************************************************
  pcecs_ident u_ident (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .smbus_id_we      (smbus_id_we),
    .smbus_id_data    (smbus_id_data),
    .eeprom_id_we     (eeprom_id_we),
    .eeprom_id_data   (eeprom_id_data),
    .maker_identifier (maker_identifier)
  );

  pcecs_pbmem #(.DEPTH(PB_DEPTH)) u_pbmem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wr_en   (pb_we),
    .wr_idx  (pb_widx),
    .wr_data (pb_wdata),
    .rd_sel  (power_budget_selector[7:0]),
    .rd_data (power_budget_value)
  );

  // ***************************************************************
  // error reporting status and control
  // ***************************************************************
  // sticky error flags, set wins over clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      uncorrectable_fault_flags <= ZERO32;
      correctable_fault_flags   <= ZERO32;
    end else begin
      uncorrectable_fault_flags <= (cfg_wr && cfg_addr == OFS_UNC_FLAGS)
                                   ? w1c(uncorrectable_fault_flags, cfg_wdata, cfg_be, unc_event)
                                   : (uncorrectable_fault_flags | unc_event);
      correctable_fault_flags   <= (cfg_wr && cfg_addr == OFS_COR_FLAGS)
                                   ? w1c(correctable_fault_flags, cfg_wdata, cfg_be, cor_event)
                                   : (correctable_fault_flags | cor_event);
    end
  end

  // error mask, severity, control writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      uncorrectable_fault_mask     <= ZERO32;
      uncorrectable_fault_severity <= ZERO32;
      correctable_fault_mask       <= ZERO32;
      error_report_cap_control     <= ZERO32;
    end else if (cfg_wr) begin
      if (cfg_addr == OFS_UNC_MASK) begin
        uncorrectable_fault_mask <= be_merge(uncorrectable_fault_mask, cfg_wdata, cfg_be, WMASK_FULL);
      end else if (cfg_addr == OFS_UNC_SEV) begin
        uncorrectable_fault_severity <= be_merge(uncorrectable_fault_severity, cfg_wdata, cfg_be, WMASK_FULL);
      end else if (cfg_addr == OFS_COR_MASK) begin
        correctable_fault_mask <= be_merge(correctable_fault_mask, cfg_wdata, cfg_be, WMASK_FULL);
      end else if (cfg_addr == OFS_ERR_CTRL) begin
        error_report_cap_control <= be_merge(error_report_cap_control, cfg_wdata, cfg_be, WMASK_ERR_CTRL);
      end
    end
  end

  // header log captured on every hlog_we pulse, latest one kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      faulting_header_record <= '0;
    end else if (hlog_we) begin
      faulting_header_record <= hlog_data;
    end
  end

  // mask and severity drive the fault handling logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      unc_mask_out <= ZERO32;
      unc_sev_out  <= ZERO32;
      cor_mask_out <= ZERO32;
    end else begin
      unc_mask_out <= uncorrectable_fault_mask;
      unc_sev_out  <= uncorrectable_fault_severity;
      cor_mask_out <= correctable_fault_mask;
    end
  end

  // ***************************************************************
  // virtual channel, power budget, access control, latency
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port_channel_ctrl_status  <= ZERO32;
      channel0_resource_control <= 32'h8000_00FF;
      channel1_resource_control <= ZERO32;
      power_budget_selector     <= ZERO32;
      access_services_cap_ctrl  <= ZERO32;
      egress_permission_vector  <= ZERO32;
      max_latency_limits        <= ZERO32;
    end else if (cfg_wr) begin
      if (cfg_addr == OFS_VC_CTRL) begin
        port_channel_ctrl_status <= be_merge(port_channel_ctrl_status, cfg_wdata, cfg_be, WMASK_VC_CTRL);
      end else if (cfg_addr == OFS_VC0_RCTRL) begin
        channel0_resource_control <= be_merge(channel0_resource_control, cfg_wdata, cfg_be, WMASK_RCTRL);
      end else if (cfg_addr == OFS_VC1_RCTRL) begin
        channel1_resource_control <= be_merge(channel1_resource_control, cfg_wdata, cfg_be, WMASK_RCTRL);
      end else if (cfg_addr == OFS_PB_SEL) begin
        power_budget_selector <= be_merge(power_budget_selector, cfg_wdata, cfg_be, WMASK_SEL);
      end else if (cfg_addr == OFS_ACS_CTRL) begin
        access_services_cap_ctrl <= be_merge(access_services_cap_ctrl, cfg_wdata, cfg_be, WMASK_ACS_CTRL);
      end else if (cfg_addr == OFS_EGRESS) begin
        egress_permission_vector <= be_merge(egress_permission_vector, cfg_wdata, cfg_be, WMASK_EGRESS);
      end else if (cfg_addr == OFS_LTR_LAT) begin
        max_latency_limits <= be_merge(max_latency_limits, cfg_wdata, cfg_be, WMASK_LTR);
      end
      // any other address, reserved ones included, is dropped
    end
  end

  // ***************************************************************
  // read decode
  // ***************************************************************
  always_comb begin
    next_rdata = ZERO32;
    if (cfg_addr == OFS_MAKER_ID) begin
      next_rdata = {16'h0000, maker_identifier};
    end else if (cfg_addr == OFS_ERR_HDR) begin
      next_rdata = cap_hdr(CAPID_ERR, OFS_VC_HDR);
    end else if (cfg_addr == OFS_UNC_FLAGS) begin
      next_rdata = uncorrectable_fault_flags;
    end else if (cfg_addr == OFS_UNC_MASK) begin
      next_rdata = uncorrectable_fault_mask;
    end else if (cfg_addr == OFS_UNC_SEV) begin
      next_rdata = uncorrectable_fault_severity;
    end else if (cfg_addr == OFS_COR_FLAGS) begin
      next_rdata = correctable_fault_flags;
    end else if (cfg_addr == OFS_COR_MASK) begin
      next_rdata = correctable_fault_mask;
    end else if (cfg_addr == OFS_ERR_CTRL) begin
      next_rdata = error_report_cap_control;
    end else if (cfg_addr >= OFS_HLOG_FIRST && cfg_addr <= OFS_HLOG_LAST) begin
      next_rdata = faulting_header_record[32*(2'(cfg_addr[3:2] - 2'd3)) +: 32];
    end else if (cfg_addr == OFS_VC_HDR) begin
      next_rdata = cap_hdr(CAPID_VC, OFS_PB_HDR);
    end else if (cfg_addr == OFS_VC_CAP1) begin
      next_rdata = 32'h0000_0001;
    end else if (cfg_addr == OFS_VC_CAP2) begin
      next_rdata = 32'h0300_0001;
    end else if (cfg_addr == OFS_VC_CTRL) begin
      next_rdata = port_channel_ctrl_status;
    end else if (cfg_addr == OFS_VC0_RCAP) begin
      next_rdata = 32'h0400_0001;
    end else if (cfg_addr == OFS_VC0_RCTRL) begin
      next_rdata = channel0_resource_control;
    end else if (cfg_addr == OFS_VC0_RSTAT) begin
      next_rdata = ZERO32;
    end else if (cfg_addr == OFS_VC1_RCAP) begin
      next_rdata = 32'h0600_0001;
    end else if (cfg_addr == OFS_VC1_RCTRL) begin
      next_rdata = channel1_resource_control;
    end else if (cfg_addr == OFS_VC1_RSTAT) begin
      next_rdata = ZERO32;
    end else if (cfg_addr == OFS_PB_HDR) begin
      next_rdata = cap_hdr(CAPID_PB, pb_next);
    end else if (cfg_addr == OFS_PB_SEL) begin
      next_rdata = power_budget_selector;
    end else if (cfg_addr == OFS_PB_CAP) begin
      next_rdata = 32'h0000_0001;
    end else if (cfg_addr == OFS_ACS_HDR) begin
      next_rdata = cap_hdr(CAPID_ACS, NEXT_END);
    end else if (cfg_addr == OFS_ACS_CTRL) begin
      next_rdata = access_services_cap_ctrl | 32'h0000_001F;
    end else if (cfg_addr == OFS_EGRESS) begin
      next_rdata = egress_permission_vector;
    end else if (cfg_addr == OFS_LTR_HDR) begin
      next_rdata = cap_hdr(CAPID_LTR, NEXT_END);
    end else if (cfg_addr == OFS_LTR_LAT) begin
      next_rdata = max_latency_limits;
    end
  end

  assign hit_rd = cfg_rd && !cfg_wr;

  // stage one: capture decoded word; power budget value from table
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      direct_q  <= ZERO32;
      use_pb_q  <= 1'b0;
    end else begin
      direct_q  <= next_rdata;
      use_pb_q  <= hit_rd && cfg_addr == OFS_PB_DATA;
    end
  end

  // stage two: answer, two cycles after the read strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_rdata  <= ZERO32;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= 1'b0;
      if (pending_q) begin
        cfg_rvalid <= 1'b1;
        cfg_rdata  <= use_pb_q ? power_budget_value : direct_q;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= hit_rd;
    end
  end

endmodule // pcecs_map

// ===== src/pcecs_pbmem.sv
`timescale 1ns/1ps

// ***************************************************************
// power budget table, registered read data
// ***************************************************************
module pcecs_pbmem #(
  parameter int DEPTH = 4
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [31:0]              wr_data,
  input  wire logic [7:0]               rd_sel,
  output logic      [31:0]              rd_data
);

  logic [31:0] table_mem [DEPTH];

  // table loaded by the device's own power setup
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      table_mem[wr_idx] <= wr_data;
    end
  end

  // out-of-range selector reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_sel < 8'(DEPTH)) begin
      rd_data <= table_mem[rd_sel[$clog2(DEPTH)-1:0]];
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

endmodule // pcecs_pbmem

// ===== src/pcecs_pkg.sv
package pcecs_pkg;

  // ***************************************************************
  // register offsets (byte addresses of configuration space)
  // ***************************************************************
  localparam logic [11:0] OFS_MAKER_ID      = 12'h000;
  localparam logic [11:0] OFS_ERR_HDR       = 12'h100;
  localparam logic [11:0] OFS_UNC_FLAGS     = 12'h104;
  localparam logic [11:0] OFS_UNC_MASK      = 12'h108;
  localparam logic [11:0] OFS_UNC_SEV       = 12'h10C;
  localparam logic [11:0] OFS_COR_FLAGS     = 12'h110;
  localparam logic [11:0] OFS_COR_MASK      = 12'h114;
  localparam logic [11:0] OFS_ERR_CTRL      = 12'h118;
  localparam logic [11:0] OFS_HLOG_FIRST    = 12'h11C;
  localparam logic [11:0] OFS_HLOG_LAST     = 12'h128;
  localparam logic [11:0] OFS_VC_HDR        = 12'h140;
  localparam logic [11:0] OFS_VC_CAP1       = 12'h144;
  localparam logic [11:0] OFS_VC_CAP2       = 12'h148;
  localparam logic [11:0] OFS_VC_CTRL       = 12'h14C;
  localparam logic [11:0] OFS_VC0_RCAP      = 12'h150;
  localparam logic [11:0] OFS_VC0_RCTRL     = 12'h154;
  localparam logic [11:0] OFS_VC0_RSTAT     = 12'h158;
  localparam logic [11:0] OFS_VC1_RCAP      = 12'h15C;
  localparam logic [11:0] OFS_VC1_RCTRL     = 12'h160;
  localparam logic [11:0] OFS_VC1_RSTAT     = 12'h164;
  localparam logic [11:0] OFS_PB_HDR        = 12'h20C;
  localparam logic [11:0] OFS_PB_SEL        = 12'h210;
  localparam logic [11:0] OFS_PB_DATA       = 12'h214;
  localparam logic [11:0] OFS_PB_CAP        = 12'h218;
  localparam logic [11:0] OFS_ACS_HDR       = 12'h220;
  localparam logic [11:0] OFS_ACS_CTRL      = 12'h224;
  localparam logic [11:0] OFS_EGRESS        = 12'h228;
  localparam logic [11:0] OFS_LTR_HDR       = 12'h230;
  localparam logic [11:0] OFS_LTR_LAT       = 12'h234;

  // ***************************************************************
  // capability header fields
  // ***************************************************************
  localparam logic [15:0] CAPID_ERR         = 16'h0001;
  localparam logic [15:0] CAPID_VC          = 16'h0002;
  localparam logic [15:0] CAPID_PB          = 16'h0004;
  localparam logic [15:0] CAPID_ACS         = 16'h000D;
  localparam logic [15:0] CAPID_LTR         = 16'h0018;
  localparam logic [3:0]  CAP_VERSION       = 4'h1;
  localparam logic [11:0] NEXT_END          = 12'h000;
  localparam int          NEXT_LSB          = 20;
  localparam int          VER_LSB           = 16;

  // ***************************************************************
  // reset values and writable masks
  // ***************************************************************
  localparam logic [15:0] MAKER_ID_RESET    = 16'h1A2B; // arbitrary value
  localparam logic [31:0] ZERO32            = 32'h0000_0000;
  localparam logic [31:0] WMASK_FULL        = 32'hFFFF_FFFF;
  localparam logic [31:0] WMASK_SEL         = 32'h0000_00FF;
  localparam logic [31:0] WMASK_ACS_CTRL    = 32'h007F_0000;
  localparam logic [31:0] WMASK_EGRESS      = 32'h0000_0007;
  localparam logic [31:0] WMASK_LTR         = 32'h1FFF_1FFF;
  localparam logic [31:0] WMASK_VC_CTRL     = 32'h0000_000F;
  localparam logic [31:0] WMASK_RCTRL       = 32'h870F_00FE;
  localparam logic [31:0] WMASK_ERR_CTRL    = 32'h0000_0140;
  localparam int          PB_ENTRIES        = 4;

endpackage : pcecs_pkg

// ===== testbench/pcecs_map_asserts.sv
`timescale 1ns/1ps

// ***************************************************************
// checker on the configuration map ports
// ***************************************************************
module pcecs_map_asserts
  import pcecs_pkg::*;
#(
  parameter bit PB_NEXT_TO_LTR = 1'b0
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        cfg_rd,
  input wire logic        cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic        smbus_id_we,
  input wire logic [15:0] smbus_id_data,
  input wire logic        eeprom_id_we,
  input wire logic [31:0] unc_mask_out
);
  // read taken this cycle and expected power budget link
  logic        rd_take;
  logic [11:0] pb_next;
  assign rd_take = cfg_rd && !cfg_wr;
  assign pb_next = PB_NEXT_TO_LTR ? OFS_LTR_HDR : OFS_ACS_HDR;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_read_answer_delay: assert property (rd_take |-> ##2 cfg_rvalid)
    else $error("read answer missing two cycles after request");
  a_valid_has_cause: assert property (cfg_rvalid |-> $past(rd_take, 2))
    else $error("read valid without a read request");
  a_first_cap_header: assert property (rd_take && cfg_addr == OFS_ERR_HDR |->
    ##2 cfg_rdata == {OFS_VC_HDR, CAP_VERSION, CAPID_ERR})
    else $error("first extended header wrong");
  a_vc_chain_link: assert property (rd_take && cfg_addr == OFS_VC_HDR |->
    ##2 cfg_rdata == {OFS_PB_HDR, CAP_VERSION, CAPID_VC})
    else $error("channel header link wrong");
  a_pb_chain_link: assert property (rd_take && cfg_addr == OFS_PB_HDR |->
    ##2 (cfg_rdata[31:20] == pb_next && cfg_rdata[15:0] == CAPID_PB))
    else $error("power budget header link wrong");
  a_chain_end_null: assert property (rd_take && (cfg_addr == OFS_ACS_HDR || cfg_addr == OFS_LTR_HDR) |->
    ##2 cfg_rdata[31:20] == NEXT_END)
    else $error("last capability does not end the chain");
  a_reserved_reads_zero: assert property (rd_take && ((cfg_addr >= 12'h12C && cfg_addr <= 12'h13F) ||
    (cfg_addr >= 12'h200 && cfg_addr <= 12'h20B)) |-> ##2 cfg_rdata == ZERO32)
    else $error("reserved range read not zero");
  a_ident_smbus_load: assert property (smbus_id_we ##1 (rd_take && cfg_addr == OFS_MAKER_ID &&
    !smbus_id_we && !eeprom_id_we) |-> ##2 cfg_rdata[15:0] == $past(smbus_id_data, 3))
    else $error("maker identifier not loaded from smbus");
  a_mask_write_out: assert property (cfg_wr && cfg_addr == OFS_UNC_MASK && cfg_be == 4'hF ##1 !cfg_wr |->
    ##1 unc_mask_out == $past(cfg_wdata, 2))
    else $error("mask output does not follow write");

  // main scenarios
  c_header_read: cover property (rd_take && cfg_addr == OFS_ERR_HDR);
  c_both_id_loads: cover property (smbus_id_we && eeprom_id_we);
  c_flag_clear: cover property (cfg_wr && cfg_addr == OFS_UNC_FLAGS);
endmodule // pcecs_map_asserts

bind pcecs_map pcecs_map_asserts #(.PB_NEXT_TO_LTR(PB_NEXT_TO_LTR)) i_pcecs_map_asserts (
  .clk_sys(clk_sys), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .smbus_id_we(smbus_id_we), .smbus_id_data(smbus_id_data), .eeprom_id_we(eeprom_id_we),
  .unc_mask_out(unc_mask_out));

// ===== testbench/pcecs_map_test.sv
`timescale 1ns/1ps

module pcecs_map_test
  import pcecs_pkg::*;
();
  // ***************************************************************
  // stimulus signals
  // ***************************************************************
  logic         clk_sys, rst, cfg_rd, cfg_wr, cfg_rvalid, smbus_id_we, eeprom_id_we, hlog_we, pb_we;
  logic [11:0]  cfg_addr;
  logic [3:0]   cfg_be;
  logic [1:0]   pb_widx;
  logic [15:0]  smbus_id_data, eeprom_id_data;
  logic [31:0]  cfg_wdata, cfg_rdata, unc_event, cor_event, pb_wdata, unc_mask_out, unc_sev_out, rd_val, cor_mask_out;
  logic [127:0] hlog_data;
  int           err_total, comparisons, i;
  logic [11:0]  hdr_ofs [5] = '{OFS_ERR_HDR, OFS_VC_HDR, OFS_PB_HDR, OFS_ACS_HDR, OFS_LTR_HDR};
  logic [31:0]  hdr_exp [5] = '{{OFS_VC_HDR, CAP_VERSION, CAPID_ERR}, {OFS_PB_HDR, CAP_VERSION, CAPID_VC},
                              {OFS_ACS_HDR, CAP_VERSION, CAPID_PB}, {NEXT_END, CAP_VERSION, CAPID_ACS},
                              {NEXT_END, CAP_VERSION, CAPID_LTR}};
  logic [11:0]  rsv_ofs [4] = '{12'h12C, 12'h13C, 12'h200, 12'h208};

  // clock generator
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  pcecs_map #(.PB_NEXT_TO_LTR(1'b0), .PB_DEPTH(PB_ENTRIES)) i_pcecs_map (
    .clk_sys(clk_sys), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .smbus_id_we(smbus_id_we),
    .smbus_id_data(smbus_id_data), .eeprom_id_we(eeprom_id_we), .eeprom_id_data(eeprom_id_data),
    .unc_event(unc_event), .cor_event(cor_event), .hlog_we(hlog_we), .hlog_data(hlog_data), .pb_we(pb_we),
    .pb_widx(pb_widx), .pb_wdata(pb_wdata), .unc_mask_out(unc_mask_out), .unc_sev_out(unc_sev_out),
    .cor_mask_out(cor_mask_out));

  // ***************************************************************
  // access tasks, all entered and left at a falling edge
  // ***************************************************************
  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
    end
  endtask

  task automatic cfg_read(input logic [11:0] addr, output logic [31:0] data);
    int n;
    n = 0;
    cfg_addr = addr;
    cfg_rd = 1'b1;
    @(negedge clk_sys);
    cfg_rd = 1'b0;
    while (cfg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    check32({31'h0, cfg_rvalid}, 32'h1, 32'h1);
    data = cfg_rdata;
  endtask

  task automatic cfg_write(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] data,
                           input logic [31:0] ev);
    cfg_addr = addr;
    cfg_be = be;
    cfg_wdata = data;
    unc_event = ev;
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    unc_event = 32'h0;
    @(negedge clk_sys);
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic [31:0] msk);
    cfg_read(addr, rd_val);
    check32(rd_val, exp, msk);
  endtask

  task automatic final_report();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    {err_total, comparisons} = '0;
    {cfg_rd, cfg_wr, smbus_id_we, eeprom_id_we, hlog_we, pb_we, pb_widx} = '0;
    {cfg_addr, cfg_be, cfg_wdata, unc_event, cor_event, pb_wdata} = '0;
    {smbus_id_data, eeprom_id_data, hlog_data} = '0;
    rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    // maker identifier: reset value, read only, both load paths
    rd_chk(OFS_MAKER_ID, {16'h0, MAKER_ID_RESET}, 32'h0000_FFFF);
    cfg_write(OFS_MAKER_ID, 4'hF, 32'hFFFF_FFFF, 32'h0);
    rd_chk(OFS_MAKER_ID, {16'h0, MAKER_ID_RESET}, 32'h0000_FFFF);
    eeprom_id_we = 1'b1;
    eeprom_id_data = 16'h5A5A;
    @(negedge clk_sys);
    eeprom_id_we = 1'b0;
    rd_chk(OFS_MAKER_ID, 32'h0000_5A5A, 32'h0000_FFFF);
    {smbus_id_we, eeprom_id_we, smbus_id_data, eeprom_id_data} = {2'b11, 16'hC3C3, 16'h3C3C};
    @(negedge clk_sys);
    {smbus_id_we, eeprom_id_we} = 2'b00;
    rd_chk(OFS_MAKER_ID, 32'h0000_C3C3, 32'h0000_FFFF);
    // capability chain headers
    for (i = 0; i < 5; i++) begin
      rd_chk(hdr_ofs[i], hdr_exp[i], 32'hFFFF_FFFF);
    end
    // reserved ranges ignore writes and read zero
    for (i = 0; i < 4; i++) begin
      cfg_write(rsv_ofs[i], 4'hF, 32'hFFFF_FFFF, 32'h0);
      rd_chk(rsv_ofs[i], 32'h0, 32'hFFFF_FFFF);
    end
    // mask and severity with byte lanes
    cfg_write(OFS_UNC_MASK, 4'hF, 32'h1234_5678, 32'h0);
    check32(unc_mask_out, 32'h1234_5678, 32'hFFFF_FFFF);
    cfg_write(OFS_UNC_MASK, 4'h2, 32'hFFFF_FFFF, 32'h0);
    rd_chk(OFS_UNC_MASK, 32'h1234_FF78, 32'hFFFF_FFFF);
    cfg_write(OFS_COR_MASK, 4'hF, 32'h0000_3001, 32'h0);
    check32(cor_mask_out, 32'h0000_3001, 32'hFFFF_FFFF);
    cfg_write(OFS_ERR_CTRL, 4'hF, 32'hFFFF_FFFF, 32'h0);
    rd_chk(OFS_ERR_CTRL, 32'h0000_0140, 32'hFFFF_FFFF);
    cfg_write(OFS_UNC_SEV, 4'hF, 32'hA5A5_0F0F, 32'h0);
    rd_chk(OFS_UNC_SEV, 32'hA5A5_0F0F, 32'hFFFF_FFFF);
    check32(unc_sev_out, 32'hA5A5_0F0F, 32'hFFFF_FFFF);
    // sticky flags: set, clear, clear racing a new event
    {unc_event, cor_event} = {32'h0000_0010, 32'h0000_0001};
    @(negedge clk_sys);
    {unc_event, cor_event} = '0;
    rd_chk(OFS_UNC_FLAGS, 32'h0000_0010, 32'hFFFF_FFFF);
    rd_chk(OFS_COR_FLAGS, 32'h0000_0001, 32'hFFFF_FFFF);
    cfg_write(OFS_COR_FLAGS, 4'hF, 32'hFFFF_FFFF, 32'h0);
    rd_chk(OFS_COR_FLAGS, 32'h0, 32'hFFFF_FFFF);
    rd_chk(OFS_UNC_FLAGS, 32'h0000_0010, 32'hFFFF_FFFF);
    cfg_write(OFS_UNC_FLAGS, 4'hF, 32'h0000_0010, 32'h0);
    rd_chk(OFS_UNC_FLAGS, 32'h0, 32'hFFFF_FFFF);
    cfg_write(OFS_UNC_FLAGS, 4'hF, 32'h0000_0010, 32'h0000_0010);
    rd_chk(OFS_UNC_FLAGS, 32'h0000_0010, 32'hFFFF_FFFF);
    // header log words
    hlog_data = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
    hlog_we = 1'b1;
    @(negedge clk_sys);
    hlog_we = 1'b0;
    for (i = 0; i < 4; i++) begin
      rd_chk(OFS_HLOG_FIRST + 12'(4 * i), hlog_data[32 * i +: 32], 32'hFFFF_FFFF);
    end
    // power budget table through the selector
    {pb_we, pb_widx, pb_wdata} = {1'b1, 2'd2, 32'h00AB_0042};
    @(negedge clk_sys);
    pb_we = 1'b0;
    cfg_write(OFS_PB_SEL, 4'hF, 32'h0000_0002, 32'h0);
    rd_chk(OFS_PB_SEL, 32'h0000_0002, 32'h0000_00FF);
    rd_chk(OFS_PB_DATA, 32'h00AB_0042, 32'hFFFF_FFFF);
    cfg_write(OFS_PB_SEL, 4'hF, 32'h0000_0009, 32'h0);
    rd_chk(OFS_PB_DATA, 32'h0, 32'hFFFF_FFFF);
    rd_chk(OFS_PB_CAP, 32'h0000_0001, 32'hFFFF_FFFF);
    final_report();
  end

  // watchdog against a hung handshake
  initial begin
    #(40 * 4000);
    err_total++;
    final_report();
  end
endmodule // pcecs_map_test
